// ---- rtl/mcd_core.sv ----
// Microinstruction fetch/execute sequencer with byte datapath
//
// Overview of operation
// - Storage bus: two bytes, each even parity.
// - Storage bus serves fetch, data access, display.
// - Outbound byte bus: byte plus parity.
// - Sixteen-bit address to storage or read-only store.
// - Display adapter steals address bus cycles.
// - Read data register captures words, forwards operands.
// - Sixteen-bit pointer addresses storage.
// - Operation register holds fetched microinstruction.
// - Byte input register loads inbound bus.
// - ALU operand register feeds ALU, outbound bus.
// - Eight-bit ALU, arithmetic or logical.
// - Internal registers are lowest 128 bytes.
// - Control decode drives all gating.
// - Cycles built from 66.2 ns slots.
// - Fetch: 3, 8, 3 slot cycles.
// - One to five execute cycles, 3/8 slots.
// - Fetch 1 loads pointer from register 0.
// - Fetch 2 reads microinstruction into operation register.
// - Fetch 3 writes pointer plus two back.
// - Execute addresses read/write storage only.
// - Sixteen word registers per level.
// - Highest active interrupt level selected after instruction.
`timescale 1ns/1ns
`default_nettype none
`include "mcd_defs.svh"
module mcd_core (
   input  wire logic                clk_i,
   input  wire logic                rst_b_i,
   input  wire logic [3:0]          irq_i,
   output logic      [15:0]         stg_addr_o,
   input  wire logic [17:0]         stg_rd_data_i,
   output logic      [17:0]         stg_wr_data_o,
   output logic                     stg_rd_o,
   output logic                     stg_wr_o,
   output logic                     read_only_store_sel_o,
   input  wire logic                cs_req_i,
   input  wire logic [15:0]         cs_addr_i,
   output logic                     cs_gnt_o,
   input  wire logic [8:0]          bus_in_i,
   output logic      [8:0]          bus_out_o,
   output logic                     put_strobe_o,
   output logic                     get_strobe_o,
   output logic      [1:0]          level_o,
   output mcd_pkg::mcd_state_t      state_o,
   output logic      [15:0]         operation_register_o,
   output logic                     check_o
);
   import mcd_pkg::*;

   localparam int SLOT_CYC = `MCD_SLOT_CYC;

   mcd_state_t  state;
   logic [15:0] regs [4][16];
   logic [1:0]  lvl;
   logic [15:0] storage_address_pointer;
   logic [15:0] operation_register;
   logic [15:0] read_data_register;
   logic [7:0]  byte_input_register;
   logic [7:0]  alu_operand_register;
   logic [3:0]  pre;
   logic [3:0]  slot;
   logic [2:0]  e_cnt;
   logic        check;

   mcd_class_t  cls;
   logic        op_long;
   logic [2:0]  n_e;
   logic        last_e;
   logic [3:0]  len;
   logic        slot_end;
   logic        cyc_end;
   logic        ex_end;
   logic [15:0] ea;
   logic        ea_int;
   logic        ex_mem;
   logic        bus_busy;
   logic [15:0] int_word;
   logic [15:0] ext_word;
   logic        ext_bad;
   logic        rd_cap;
   logic [15:0] rd_now;
   logic [15:0] pc_cur;
   logic [15:0] st_word;
   logic [7:0]  alu_res;
   logic [1:0]  irq_top;

   // Control decode of the current microinstruction
   assign cls     = mcd_class_t'(operation_register[`MCD_OP_CLASS]);
   assign op_long = operation_register[`MCD_OP_LONG];
   always_comb begin
      n_e = operation_register[`MCD_OP_ECNT];
      if (n_e == 3'h0) begin
         n_e = 3'h1;
      end else if (n_e > 3'(`MCD_MAX_ECYC)) begin
         n_e = 3'(`MCD_MAX_ECYC);
      end
   end
   assign last_e = (e_cnt == n_e - 3'h1);

   always_comb begin
      case (state)
         MCD_I2:  len = 4'(`MCD_LONG_SLOTS);
         MCD_EX:  len = op_long ? 4'(`MCD_LONG_SLOTS) : 4'(`MCD_SHORT_SLOTS);
         default: len = 4'(`MCD_SHORT_SLOTS);
      endcase
   end

   // Slot timing: each slot rounds up to whole clocks
   assign slot_end = !check && (pre == 4'(SLOT_CYC - 1));
   assign cyc_end  = slot_end && (slot == len - 4'h1);
   assign ex_end   = cyc_end && (state == MCD_EX) && last_e;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pre  <= 4'h0;
         slot <= 4'h0;
      end else if (!check) begin
         pre <= slot_end ? 4'h0 : pre + 4'h1;
         if (slot_end) begin
            slot <= cyc_end ? 4'h0 : slot + 4'h1;
         end
      end
   end

   // Storage addressing; low 128 bytes map onto the level registers
   assign pc_cur  = regs[lvl][0];
   assign ea      = regs[lvl][operation_register[`MCD_OP_RA]];
   assign ea_int  = (ea < `MCD_REG_SPACE);
   assign ex_mem  = (state == MCD_EX) && op_long && !ea_int &&
                    (cls == MCD_LOAD || cls == MCD_STORE || cls == MCD_JUMP);
   assign bus_busy = (state == MCD_I2) || ex_mem;
   assign int_word = regs[ea[6:5]][ea[4:1]];
   assign ext_word = {stg_rd_data_i[16:9], stg_rd_data_i[7:0]};
   assign ext_bad  = (^stg_rd_data_i[17:9]) || (^stg_rd_data_i[8:0]);
   assign st_word  = regs[lvl][operation_register[`MCD_OP_RB]];

   always_comb begin
      stg_addr_o = (state == MCD_I2) ? storage_address_pointer : ea;
      if (!bus_busy && cs_req_i) begin
         stg_addr_o = cs_addr_i;
      end
   end
   assign cs_gnt_o = cs_req_i && !bus_busy;
   assign stg_rd_o = (state == MCD_I2) || (ex_mem && cls != MCD_STORE);
   assign stg_wr_o = ex_mem && (cls == MCD_STORE);
   assign stg_wr_data_o = {^st_word[15:8], st_word[15:8], ^st_word[7:0], st_word[7:0]};
   assign read_only_store_sel_o = (state == MCD_I2) && storage_address_pointer[`MCD_ROM_BIT];

   // Word read this cycle, forwarded in the same edge it is captured
   assign rd_cap = cyc_end && ((state == MCD_EX && op_long && ea_int) || ex_mem) && cls != MCD_STORE;
   assign rd_now = rd_cap ? (ea_int ? int_word : ext_word) : read_data_register;

   always_comb begin
      case (operation_register[`MCD_OP_FN])
         2'h0:    alu_res = alu_operand_register + byte_input_register;
         2'h1:    alu_res = alu_operand_register - byte_input_register;
         2'h2:    alu_res = alu_operand_register & byte_input_register;
         default: alu_res = alu_operand_register | byte_input_register;
      endcase
   end

   always_comb begin
      irq_top = 2'h0;
      for (int i = 0; i < 4; i++) begin
         if (irq_i[i]) begin
            irq_top = 2'(i);
         end
      end
   end

   // Cycle sequencer
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state <= MCD_I1;
         e_cnt <= 3'h0;
      end else if (cyc_end) begin
         case (state)
            MCD_I1:  state <= MCD_I2;
            MCD_I2:  state <= MCD_I3;
            MCD_I3:  state <= MCD_EX;
            MCD_EX: begin
               e_cnt <= last_e ? 3'h0 : e_cnt + 3'h1;
               if (last_e) begin
                  state <= MCD_I1;
               end
            end
            default: state <= MCD_I1;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         lvl <= 2'h0;
      end else if (ex_end) begin
         lvl <= irq_top;
      end
   end

   // Pointer and operation register
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         storage_address_pointer <= 16'h0000;
         operation_register      <= 16'h0000;
      end else if (cyc_end) begin
         if (state == MCD_I1) begin
            storage_address_pointer <= pc_cur;
         end else if (state == MCD_I2) begin
            operation_register <= ext_word;
         end else if (ex_end && cls == MCD_JUMP) begin
            storage_address_pointer <= rd_now;
         end
      end
   end

   // Level register file
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         for (int l = 0; l < 4; l++) begin
            for (int r = 0; r < 16; r++) begin
               regs[l][r] <= 16'h0000;
            end
         end
      end else if (cyc_end && state == MCD_I3) begin
         regs[lvl][0] <= storage_address_pointer + `MCD_PC_STEP;
      end else if (ex_end && cls == MCD_JUMP) begin
         regs[lvl][0] <= rd_now;
      end else if (ex_end && cls == MCD_STORE && ea_int) begin
         regs[ea[6:5]][ea[4:1]] <= st_word;
      end
   end

   // Datapath registers
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         read_data_register   <= 16'h0000;
         byte_input_register  <= 8'h00;
         alu_operand_register <= 8'h00;
      end else begin
         if (rd_cap) begin
            read_data_register <= rd_now;
         end
         if (ex_end && cls == MCD_GET) begin
            byte_input_register <= bus_in_i[7:0];
         end
         if (ex_end && cls == MCD_LOAD) begin
            alu_operand_register <= rd_now[7:0];
         end else if (ex_end && cls == MCD_ALU) begin
            alu_operand_register <= alu_res;
         end
      end
   end

   // Byte bus strobes and parity checking
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         bus_out_o    <= 9'h000;
         put_strobe_o <= 1'b0;
         get_strobe_o <= 1'b0;
         check        <= 1'b0;
      end else begin
         put_strobe_o <= ex_end && cls == MCD_PUT;
         get_strobe_o <= ex_end && cls == MCD_GET;
         if (ex_end && cls == MCD_PUT) begin
            bus_out_o <= {^alu_operand_register, alu_operand_register};
         end
         if ((cyc_end && bus_busy && !stg_wr_o && ext_bad) ||
             (ex_end && cls == MCD_GET && ^bus_in_i)) begin
            check <= 1'b1;
         end
      end
   end

   assign level_o              = lvl;
   assign state_o              = state;
   assign operation_register_o = operation_register;
   assign check_o              = check;

   // Checking helpers
   logic [4:0] age;
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || cyc_end) begin
         age <= 5'h00;
      end else if (!check) begin
         age <= age + 5'h01;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_cycle_len;
      cyc_end |-> age == 5'(32'(len) * SLOT_CYC - 1);
   endproperty
   a_cycle_len: assert property (p_cycle_len) else $error("cycle length wrong");
   property p_fetch_order;
      state == MCD_I1 && cyc_end |=> state == MCD_I2 ##16 state == MCD_I3;
   endproperty
   a_fetch_order: assert property (p_fetch_order) else $error("fetch order wrong");
   property p_ptr_load;
      state == MCD_I1 && cyc_end |=> storage_address_pointer == $past(pc_cur);
   endproperty
   a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
   property p_op_load;
      state == MCD_I2 && cyc_end |=> operation_register == $past(ext_word);
   endproperty
   a_op_load: assert property (p_op_load) else $error("op not loaded");
   property p_pc_step;
      state == MCD_I3 && cyc_end |=> pc_cur == $past(storage_address_pointer) + `MCD_PC_STEP;
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc not stepped");
   property p_ex_no_rom;
      state == MCD_EX && (stg_rd_o || stg_wr_o) |-> !read_only_store_sel_o && stg_addr_o >= `MCD_REG_SPACE;
   endproperty
   a_ex_no_rom: assert property (p_ex_no_rom) else $error("rom in execute");
   property p_ecnt;
      state == MCD_EX |-> e_cnt < 3'(`MCD_MAX_ECYC);
   endproperty
   a_ecnt: assert property (p_ecnt) else $error("too many execute cycles");
   property p_level;
      ex_end |=> lvl == $past(irq_top) && state == MCD_I1;
   endproperty
   a_level: assert property (p_level) else $error("level pick wrong");
   property p_steal;
      cs_gnt_o |-> stg_addr_o == cs_addr_i && !stg_rd_o && !stg_wr_o;
   endproperty
   a_steal: assert property (p_steal) else $error("steal address wrong");

   c_jump:  cover property (ex_end && cls == MCD_JUMP);
   c_store: cover property (stg_wr_o);
   c_steal: cover property (cs_gnt_o);
   c_level: cover property (ex_end && irq_top == 2'h3);
endmodule
`default_nettype wire

// ---- rtl/mcd_defs.svh ----
// Constants for the microinstruction cycle datapath
`ifndef MCD_DEFS_SVH
`define MCD_DEFS_SVH
`define MCD_CLK_PS      50000
`define MCD_SLOT_PS     66200
`define MCD_SLOT_CYC    ((`MCD_SLOT_PS + `MCD_CLK_PS - 1) / `MCD_CLK_PS)
`define MCD_SHORT_SLOTS 3
`define MCD_LONG_SLOTS  8
`define MCD_MAX_ECYC    5
`define MCD_PC_STEP     16'h0002
`define MCD_REG_SPACE   16'h0080
`define MCD_ROM_BIT     15
`define MCD_OP_CLASS    15:12
`define MCD_OP_LONG     11
`define MCD_OP_ECNT     10:8
`define MCD_OP_RA       7:4
`define MCD_OP_RB       3:0
`define MCD_OP_FN       1:0
`endif

// ---- rtl/mcd_pkg.sv ----
// Types for the microinstruction cycle datapath
package mcd_pkg;
   typedef enum logic [3:0] {
      MCD_I1 = 4'b0001,
      MCD_I2 = 4'b0010,
      MCD_I3 = 4'b0100,
      MCD_EX = 4'b1000
   } mcd_state_t;
   typedef enum logic [3:0] {
      MCD_GET   = 4'h0,
      MCD_PUT   = 4'h1,
      MCD_LOAD  = 4'h2,
      MCD_STORE = 4'h3,
      MCD_ALU   = 4'h4,
      MCD_JUMP  = 4'h5
   } mcd_class_t;
endpackage

// ---- tb/mcd_store_model.sv ----
// Storage and read-only store model on the far side of the core
`timescale 1ns/1ns
`default_nettype none
module mcd_store_model (
   input  wire logic        clk_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic        rom_sel_i,
   input  wire logic [17:0] wr_data_i,
   input  wire logic        bad_par_i,
   output logic      [17:0] rd_data_o
);
   logic [15:0] ram [0:255];
   logic [15:0] rom [0:255];
   logic [15:0] word;
   logic [17:0] last;
   assign word = rom_sel_i ? rom[addr_i[8:1]] : ram[addr_i[8:1]];
   // Released bus shows the inverse of the last word, not a stale copy
   always_comb begin
      if (rd_i) begin
         rd_data_o = {^word[15:8] ^ bad_par_i, word[15:8], ^word[7:0], word[7:0]};
      end else begin
         rd_data_o = ~last;
      end
   end
   always @(posedge clk_i) begin
      if (rd_i) begin
         last <= rd_data_o;
      end
      if (wr_i && !rom_sel_i) begin
         ram[addr_i[8:1]] <= {wr_data_i[16:9], wr_data_i[7:0]};
      end
   end
   initial last = 18'h00000;
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the microinstruction cycle core
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import mcd_pkg::*;
   logic clk_i = 1'b0, rst_b_i = 1'b0, stg_rd_o, stg_wr_o, rom_sel, cs_req_i = 1'b0, cs_gnt_o;
   logic put_strobe_o, get_strobe_o, check_o, bad_par = 1'b0;
   logic [3:0] irq_i = 4'h0;
   logic [15:0] stg_addr_o, cs_addr_i = 16'h0000, operation_register_o;
   logic [17:0] stg_rd_data_i, stg_wr_data_o;
   logic [8:0] bus_in_i = 9'h05A, bus_out_o;
   logic [1:0] level_o;
   mcd_state_t state_o;
   int num_errors = 0, checked = 0, cyc = 0, n, k;
   logic [15:0] r_ins [0:6] = '{16'h0100, 16'h1100, 16'h4000, 16'h4A01, 16'h4702, 16'h4B03, 16'h4500};
   int r_ex [0:6] = '{6, 6, 6, 32, 30, 48, 30};
   logic r_put [0:6] = '{0, 1, 0, 0, 0, 0, 0};
   logic r_get [0:6] = '{1, 0, 0, 0, 0, 0, 0};
   logic rd_seen;

   always #25 clk_i = ~clk_i;

   mcd_core i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .irq_i(irq_i), .stg_addr_o(stg_addr_o),
      .stg_rd_data_i(stg_rd_data_i), .stg_wr_data_o(stg_wr_data_o), .stg_rd_o(stg_rd_o),
      .stg_wr_o(stg_wr_o), .read_only_store_sel_o(rom_sel), .cs_req_i(cs_req_i),
      .cs_addr_i(cs_addr_i), .cs_gnt_o(cs_gnt_o), .bus_in_i(bus_in_i), .bus_out_o(bus_out_o),
      .put_strobe_o(put_strobe_o), .get_strobe_o(get_strobe_o), .level_o(level_o),
      .state_o(state_o), .operation_register_o(operation_register_o), .check_o(check_o));
   mcd_store_model i_mem (.clk_i(clk_i), .addr_i(stg_addr_o), .rd_i(stg_rd_o), .wr_i(stg_wr_o),
      .rom_sel_i(rom_sel), .wr_data_i(stg_wr_data_o), .bad_par_i(bad_par), .rd_data_o(stg_rd_data_i));

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Inputs change and outputs are read 5 ns after the rising edge
   task automatic step();
      @(posedge clk_i);
      #5;
   endtask
   task automatic wait_state(input mcd_state_t s);
      int t;
      t = 0;
      while (state_o !== s && t < 200) begin
         step();
         t++;
      end
      chk("state reached", state_o, s);
   endtask
   task automatic count_state(input mcd_state_t s, output int c);
      c = 0;
      rd_seen = 1'b0;
      while (state_o === s && c < 100) begin
         rd_seen = rd_seen | stg_rd_o | rom_sel;
         step();
         c++;
      end
   endtask

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   initial begin
      for (k = 0; k < 256; k++) begin
         i_mem.ram[k] = 16'h4000;
         i_mem.rom[k] = 16'h4000;
      end
      for (k = 0; k < 7; k++) begin
         i_mem.ram[k] = r_ins[k];
      end
      i_mem.ram[9] = 16'h0100;
      i_mem.ram[64] = 16'h2800;
      i_mem.ram[65] = 16'h11A5;
      i_mem.ram[66] = 16'h3800;
      i_mem.ram[68] = 16'h5800;
      i_mem.ram[69] = 16'h8010;
      i_mem.rom[8] = 16'h4001;
      repeat (16) step();
      chk("reset state", state_o, MCD_I1);
      chk("reset level", level_o, 2'h0);
      chk("reset read", stg_rd_o, 1'b0);
      rst_b_i = 1'b1;
      cs_req_i = 1'b1;
      cs_addr_i = 16'h1234;
      #1;
      chk("steal grant idle", cs_gnt_o, 1'b1);
      chk("steal address", stg_addr_o, 16'h1234);
      wait_state(MCD_I2);
      chk("steal refused in fetch", cs_gnt_o, 1'b0);
      cs_req_i = 1'b0;
      $display("test reset and steal done");
      for (k = 0; k < 7; k++) begin
         wait_state(MCD_I2);
         chk("fetch address", stg_addr_o, 32'(2 * k));
         chk("fetch read", stg_rd_o, 1'b1);
         count_state(MCD_I2, n);
         chk("fetch2 clocks", n, 16);
         chk("operation register", operation_register_o, r_ins[k]);
         count_state(MCD_I3, n);
         chk("fetch3 clocks", n, 6);
         count_state(MCD_EX, n);
         chk("execute clocks", n, r_ex[k]);
         chk("execute storage idle", rd_seen, 1'b0);
         chk("put strobe", put_strobe_o, r_put[k]);
         chk("get strobe", get_strobe_o, r_get[k]);
         chk("bus out parity", bus_out_o[8], ^bus_out_o[7:0]);
         count_state(MCD_I1, n);
         chk("fetch1 clocks", n, 6);
         $display("test row %0d done", k);
      end
      irq_i = 4'b1010;
      count_state(MCD_I2, n);
      wait_state(MCD_I2);
      chk("level chosen", level_o, 2'h3);
      chk("level fetch address", stg_addr_o, 16'h0000);
      irq_i = 4'h0;
      count_state(MCD_I2, n);
      wait_state(MCD_I2);
      chk("level back", level_o, 2'h0);
      chk("resume address", stg_addr_o, 16'h0010);
      $display("test interrupt levels done");
      bus_in_i = 9'h15A;
      count_state(MCD_I2, n);
      wait_state(MCD_I2);
      chk("get word", stg_addr_o, 16'h0012);
      count_state(MCD_I2, n);
      repeat (40) step();
      chk("inbound parity check", check_o, 1'b1);
      chk("halted", stg_rd_o, 1'b0);
      rst_b_i = 1'b0;
      bus_in_i = 9'h05A;
      bad_par = 1'b1;
      repeat (2) step();
      chk("check cleared", check_o, 1'b0);
      rst_b_i = 1'b1;
      wait_state(MCD_I3);
      repeat (2) step();
      chk("storage parity check", check_o, 1'b1);
      $display("test parity checks done");
      rst_b_i = 1'b0;
      bad_par = 1'b0;
      repeat (2) step();
      rst_b_i = 1'b1;
      k = 0;
      wait_state(MCD_I2);
      while (stg_addr_o !== 16'h0080 && k < 80) begin
         count_state(MCD_I2, n);
         wait_state(MCD_I2);
         k++;
      end
      chk("run up address", stg_addr_o, 16'h0080);
      count_state(MCD_I2, n);
      cs_req_i = 1'b1;
      count_state(MCD_I3, n);
      chk("load address", stg_addr_o, 16'h0082);
      chk("load read", stg_rd_o, 1'b1);
      chk("steal refused in execute", cs_gnt_o, 1'b0);
      cs_req_i = 1'b0;
      count_state(MCD_EX, n);
      chk("load clocks", n, 16);
      wait_state(MCD_I2);
      count_state(MCD_I2, n);
      chk("put word", operation_register_o, 16'h11A5);
      count_state(MCD_I3, n);
      count_state(MCD_EX, n);
      chk("put strobe data", put_strobe_o, 1'b1);
      chk("put byte", bus_out_o, 9'h0A5);
      wait_state(MCD_I2);
      count_state(MCD_I2, n);
      count_state(MCD_I3, n);
      chk("store strobe", stg_wr_o, 1'b1);
      chk("store address", stg_addr_o, 16'h0086);
      chk("store data", stg_wr_data_o, 18'h00186);
      chk("store no read", stg_rd_o, 1'b0);
      wait_state(MCD_I2);
      count_state(MCD_I2, n);
      chk("stored word fetched", operation_register_o, 16'h0086);
      wait_state(MCD_I2);
      chk("jump fetch", stg_addr_o, 16'h0088);
      count_state(MCD_I2, n);
      wait_state(MCD_I2);
      chk("jump target", stg_addr_o, 16'h8010);
      chk("read-only store select", rom_sel, 1'b1);
      count_state(MCD_I2, n);
      chk("read-only store word", operation_register_o, 16'h4001);
      $display("test storage access done");
      finish_test();
   end
endmodule
`default_nettype wire
